//--- hdl/pwm4_top.sv
// four-channel 8/16-bit pulse-width modulator with port takeover
// ********************************************
// Overview of operation
// - four 8-bit channels, or pairs joined as 16-bit channels
// - enabled channel buffers period/duty until rollover or disable
// - disabled channel writes go to buffer and active latch together
// - counter write clears counter and loads buffered period and duty
// - channel counters are readable by software
// - enabled channel owns its pin, except the low channel of a joined pair; unused pins stay general purpose
// - upper join: ch2 high byte, ch3 low, output on pin 2
// - lower join: ch0 high byte, ch1 low, output on pin 0
// - clock A is P divided by two to the field value
// - clock B uses the same division, serves channels 2 and 3
// - channels 0,1 select clock A or scaled clock 0
// - channels 2,3 select clock B or scaled clock 1
// - polarity zero starts low, goes high at duty match
// - duty counts low time for polarity zero, else high time
// - enable forces pin to output without changing direction bit
// - channel clock reaches channel only while enabled
// - prescaler stops when all four enables are clear
// - clock gating changes only on a clock edge
// - waveform appears when selected clock begins next cycle
// - duty of zero in left-aligned mode, or nonzero and at or above period, holds pin at the inverse of polarity
// - common alignment setting picks left or center alignment
// - scaled clock 0 is clock A over scale0+1, halved
// - scaled clock 1 is clock B over scale1+1, halved
// - center mode counts up and down, reversing at period match
// ********************************************
`timescale 1ns/1ps
`default_nettype none
module pwm4_top
	import pwm4_pkg::*;
(
	// clock, reset, enable
	input  wire logic              I_CLK_SYS,
	input  wire logic              I_NRST,
	input  wire logic              I_CE,
	// register port
	input  wire pwm4_pkg::bus_req_type I_BUS,
	output logic [7:0]             O_RDATA,
	// shared port pins
	input  wire logic [3:0]        I_PIN,
	output logic [3:0]             O_PIN,
	output logic [3:0]             O_PIN_OE
);
	import pwm4_pkg::*;

	// ********************************************
	// registers
	// ********************************************
	logic [7:0]   clock_prescale_and_concat_q;
	logic [7:0]   clock_select_and_polarity_q;
	logic [3:0]   channel_enable_q;
	logic         center_align_select_q;
	logic [7:0]   scale_value_0_q;
	logic [7:0]   scale_value_1_q;
	logic [3:0]   port_direction_bits_q;
	logic [3:0]   port_data_q;
	logic [6:0]   pre_q;
	logic [6:0]   pre_prev_q;
	logic [7:0]   cnt_q [NUM_CHAN];
	logic [3:0]   down_q;
	per_duty_type buf_q [NUM_CHAN];
	per_duty_type act_q [NUM_CHAN];
	logic [3:0]   wave_q;
	logic [3:0]   en_sync_q;

	logic       join_upper_pair;
	logic       join_lower_pair;
	logic [3:0] chan_scaled_sel;
	logic [3:0] channel_polarity;
	logic       any_en;
	logic       tick_a, tick_b, tick_s0, tick_s1;
	logic [7:0] scnt0, scnt1;
	logic [3:0] ch_tick;
	logic [3:0] wr_cnt, wr_per, wr_dty;
	logic [3:0] roll;
	logic [3:0] pin_active;

	assign join_upper_pair  = clock_prescale_and_concat_q[JOIN_UPPER_BIT];
	assign join_lower_pair  = clock_prescale_and_concat_q[JOIN_LOWER_BIT];
	assign chan_scaled_sel  = clock_select_and_polarity_q[SCALED_SEL_LSB +: 4];
	assign channel_polarity = clock_select_and_polarity_q[POLARITY_LSB +: 4];
	assign any_en           = |channel_enable_q;

	// ********************************************
	// control registers
	// ********************************************
	// plain byte registers, all clear at reset
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_NRST)
		begin
			clock_prescale_and_concat_q <= RST_ZERO;
			clock_select_and_polarity_q <= RST_ZERO;
			channel_enable_q            <= 4'h0;
			center_align_select_q       <= 1'b0;
			scale_value_0_q             <= RST_ZERO;
			scale_value_1_q             <= RST_ZERO;
			port_direction_bits_q       <= 4'h0;
			port_data_q                 <= 4'h0;
		end
		else if (I_CE && I_BUS.wr)
		begin
			if (I_BUS.addr == ADDR_CLK_CONCAT)
				clock_prescale_and_concat_q <= I_BUS.wdata;
			else if (I_BUS.addr == ADDR_SEL_POL)
				clock_select_and_polarity_q <= I_BUS.wdata;
			else if (I_BUS.addr == ADDR_ENABLE)
				channel_enable_q <= I_BUS.wdata[3:0];
			else if (I_BUS.addr == ADDR_CONTROL)
				center_align_select_q <= I_BUS.wdata[CENTER_ALIGN_BIT];
			else if (I_BUS.addr == ADDR_SCALE0)
				scale_value_0_q <= I_BUS.wdata;
			else if (I_BUS.addr == ADDR_SCALE1)
				scale_value_1_q <= I_BUS.wdata;
			else if (I_BUS.addr == ADDR_PORT_DIR)
				port_direction_bits_q <= I_BUS.wdata[3:0];
			else if (I_BUS.addr == ADDR_PORT_DATA)
				port_data_q <= I_BUS.wdata[3:0];
		end
	end

	// ********************************************
	// shared prescaler
	// ********************************************
	// frozen while no channel runs, saving toggling power
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_NRST)
		begin
			pre_q      <= 7'h00;
			pre_prev_q <= 7'h00;
		end
		else if (I_CE && any_en)
		begin
			pre_q      <= pre_q + 7'h01;
			pre_prev_q <= pre_q;
		end
	end

	pwm4_scaler u_scaler_a
	(
		.i_clk         (I_CLK_SYS),
		.i_nrst        (I_NRST),
		.i_ce          (I_CE),
		.i_run         (any_en),
		.i_pre_cnt     (pre_q),
		.i_pre_prev    (pre_prev_q),
		.i_div_sel     (clock_prescale_and_concat_q[CLKA_FIELD_LSB +: 3]),
		.i_scale       (scale_value_0_q),
		.i_scale_load  (I_BUS.wr && I_BUS.addr == ADDR_SCALE0),
		.o_tick_base   (tick_a),
		.o_tick_scaled (tick_s0),
		.o_scnt        (scnt0)
	);

	pwm4_scaler u_scaler_b
	(
		.i_clk         (I_CLK_SYS),
		.i_nrst        (I_NRST),
		.i_ce          (I_CE),
		.i_run         (any_en),
		.i_pre_cnt     (pre_q),
		.i_pre_prev    (pre_prev_q),
		.i_div_sel     (clock_prescale_and_concat_q[CLKB_FIELD_LSB +: 3]),
		.i_scale       (scale_value_1_q),
		.i_scale_load  (I_BUS.wr && I_BUS.addr == ADDR_SCALE1),
		.o_tick_base   (tick_b),
		.o_tick_scaled (tick_s1),
		.o_scnt        (scnt1)
	);

	// ********************************************
	// per-channel clock select and gating
	// ********************************************
	// the enable is registered so gating only changes on an edge;
	// a joined pair runs both halves on the low channel's clock
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_NRST)
			en_sync_q <= 4'h0;
		else if (I_CE)
			en_sync_q <= channel_enable_q;
	end

	always_comb
	begin
		ch_tick[0] = chan_scaled_sel[join_lower_pair ? 1 : 0] ? tick_s0 : tick_a;
		ch_tick[1] = chan_scaled_sel[1] ? tick_s0 : tick_a;
		ch_tick[2] = chan_scaled_sel[join_upper_pair ? 3 : 2] ? tick_s1 : tick_b;
		ch_tick[3] = chan_scaled_sel[3] ? tick_s1 : tick_b;
		ch_tick[0] = ch_tick[0] & en_sync_q[join_lower_pair ? 0 : 0];
		ch_tick[1] = ch_tick[1] & en_sync_q[join_lower_pair ? 0 : 1];
		ch_tick[2] = ch_tick[2] & en_sync_q[2];
		ch_tick[3] = ch_tick[3] & en_sync_q[join_upper_pair ? 2 : 3];
	end

	// ********************************************
	// channel counters, buffers and waveform
	// ********************************************
	genvar g;
	generate
		for (g = 0; g < NUM_CHAN; g++)
		begin : g_chan
			localparam int HI = (g < 2) ? 0 : 2;
			logic        joined;
			logic        is_low;
			logic [15:0] cnt16, per16, dty16;
			logic        top_hit;
			logic        up_now;
			logic        en_eff;

			assign joined = (g < 2) ? join_lower_pair : join_upper_pair;
			assign is_low = (g == HI + 1);
			assign en_eff = joined ? channel_enable_q[HI] : channel_enable_q[g];
			assign wr_cnt[g] = I_BUS.wr && I_BUS.addr == ADDR_CNT_BASE + 8'(g);
			assign wr_per[g] = I_BUS.wr && I_BUS.addr == ADDR_PER_BASE + 8'(g);
			assign wr_dty[g] = I_BUS.wr && I_BUS.addr == ADDR_DTY_BASE + 8'(g);
			// joined pair compares as one 16-bit value, high byte first
			assign cnt16 = joined ? {cnt_q[HI], cnt_q[HI+1]} : {8'h00, cnt_q[g]};
			assign per16 = joined ? {act_q[HI].period, act_q[HI+1].period}
				: {8'h00, act_q[g].period};
			assign dty16 = joined ? {act_q[HI].duty, act_q[HI+1].duty}
				: {8'h00, act_q[g].duty};
			assign top_hit = (cnt16 >= per16);
			assign roll[g] = ch_tick[joined ? HI + 1 : g] & top_hit
				& ~center_align_select_q;
			assign up_now = ~down_q[joined ? HI + 1 : g];

			// double buffer: straight through while disabled
			always_ff @(posedge I_CLK_SYS)
			begin
				if (!I_NRST)
				begin
					buf_q[g] <= '{RST_PERIOD, RST_DUTY};
					act_q[g] <= '{RST_PERIOD, RST_DUTY};
				end
				else if (I_CE)
				begin
					if (wr_per[g])
						buf_q[g].period <= I_BUS.wdata;
					if (wr_dty[g])
						buf_q[g].duty <= I_BUS.wdata;
					if (!en_eff)
					begin
						if (wr_per[g])
							act_q[g].period <= I_BUS.wdata;
						else
							act_q[g].period <= buf_q[g].period;
						if (wr_dty[g])
							act_q[g].duty <= I_BUS.wdata;
						else
							act_q[g].duty <= buf_q[g].duty;
					end
					else if (wr_cnt[joined ? HI + 1 : g] || wr_cnt[joined ? HI : g]
						|| roll[joined ? HI + 1 : g]
						|| (center_align_select_q && ch_tick[joined ? HI + 1 : g]
						&& cnt16 == 16'h0000 && up_now))
						act_q[g] <= buf_q[g];
				end
			end

			// counter: low byte ticks, high byte takes carries when joined
			always_ff @(posedge I_CLK_SYS)
			begin
				if (!I_NRST)
				begin
					cnt_q[g]  <= RST_ZERO;
					down_q[g] <= 1'b0;
				end
				else if (I_CE)
				begin
					if (wr_cnt[joined ? HI + 1 : g] || wr_cnt[joined ? HI : g])
					begin
						cnt_q[g]  <= RST_ZERO;
						down_q[g] <= 1'b0;
					end
					else if (ch_tick[joined ? HI + 1 : g])
					begin
						if (!center_align_select_q)
							cnt_q[g] <= top_hit ? RST_ZERO :
								(joined && !is_low) ? 8'(cnt16[15:8]
								+ 8'((cnt16[7:0] == 8'hFF) ? 1 : 0))
								: 8'(cnt16[7:0] + 8'h01) ;
						else if (up_now)
						begin
							if (cnt16 + 16'h0001 >= per16)
								down_q[g] <= 1'b1;
							cnt_q[g] <= (joined && !is_low) ? 8'(cnt16[15:8]
								+ 8'((cnt16[7:0] == 8'hFF) ? 1 : 0))
								: 8'(cnt16[7:0] + 8'h01);
						end
						else
						begin
							if (cnt16 <= 16'h0001)
								down_q[g] <= 1'b0;
							cnt_q[g] <= (joined && !is_low) ? 8'(cnt16[15:8]
								- 8'((cnt16[7:0] == 8'h00) ? 1 : 0))
								: 8'(cnt16[7:0] - 8'h01);
						end
					end
				end
			end

			// output: polarity sets starting level, duty match flips it
			always_ff @(posedge I_CLK_SYS)
			begin
				if (!I_NRST)
					wave_q[g] <= 1'b0;
				else if (I_CE)
				begin
					if (dty16 >= per16 && !(dty16 == 16'h0000 && per16 == 16'h0000))
						wave_q[g] <= ~channel_polarity[g];
					else if (cnt16 < dty16 || (center_align_select_q && cnt16 == dty16))
						wave_q[g] <= channel_polarity[g];
					else
						wave_q[g] <= ~channel_polarity[g];
				end
			end
		end
	endgenerate

	// ********************************************
	// pin takeover
	// ********************************************
	// joined low channel's pin returns to the general-purpose port
	assign pin_active[0] = channel_enable_q[0];
	assign pin_active[1] = channel_enable_q[1] & ~join_lower_pair;
	assign pin_active[2] = channel_enable_q[2];
	assign pin_active[3] = channel_enable_q[3] & ~join_upper_pair;

	// outputs registered; waveform shows once the channel clock ticks
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_NRST)
		begin
			O_PIN    <= 4'h0;
			O_PIN_OE <= 4'h0;
		end
		else if (I_CE)
		begin
			O_PIN    <= (pin_active & wave_q) | (~pin_active & port_data_q);
			O_PIN_OE <= pin_active | port_direction_bits_q;
		end
	end

	// ********************************************
	// read port
	// ********************************************
	// reads have no side effects, so counters read freely
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_NRST)
			O_RDATA <= RST_ZERO;
		else if (I_CE)
		begin
			if (!I_BUS.rd)
				O_RDATA <= RST_ZERO;
			else if (I_BUS.addr == ADDR_CLK_CONCAT)
				O_RDATA <= clock_prescale_and_concat_q;
			else if (I_BUS.addr == ADDR_SEL_POL)
				O_RDATA <= clock_select_and_polarity_q;
			else if (I_BUS.addr == ADDR_ENABLE)
				O_RDATA <= {4'h0, channel_enable_q};
			else if (I_BUS.addr == ADDR_PRESCALE)
				O_RDATA <= {1'b0, pre_q};
			else if (I_BUS.addr == ADDR_SCALE0)
				O_RDATA <= scale_value_0_q;
			else if (I_BUS.addr == ADDR_SCNT0)
				O_RDATA <= scnt0;
			else if (I_BUS.addr == ADDR_SCALE1)
				O_RDATA <= scale_value_1_q;
			else if (I_BUS.addr == ADDR_SCNT1)
				O_RDATA <= scnt1;
			else if (I_BUS.addr[7:2] == ADDR_CNT_BASE[7:2])
				O_RDATA <= cnt_q[I_BUS.addr[1:0]];
			else if (I_BUS.addr[7:2] == ADDR_PER_BASE[7:2])
				O_RDATA <= buf_q[I_BUS.addr[1:0]].period;
			else if (I_BUS.addr[7:2] == ADDR_DTY_BASE[7:2])
				O_RDATA <= buf_q[I_BUS.addr[1:0]].duty;
			else if (I_BUS.addr == ADDR_CONTROL)
				O_RDATA <= {4'h0, center_align_select_q, 3'h0};
			else if (I_BUS.addr == ADDR_PORT_DIR)
				O_RDATA <= {4'h0, port_direction_bits_q};
			else if (I_BUS.addr == ADDR_PORT_DATA)
				O_RDATA <= {4'h0, I_PIN};
			else
				O_RDATA <= RST_ZERO;
		end
	end

	// ********************************************
	// checks
	// ********************************************
	a_prescale_idle: assert property (@(posedge I_CLK_SYS)
		disable iff (!I_NRST) (I_CE && !any_en) |=> $stable(pre_q))
		else $error("prescaler moved with all channels off");
	a_enable_drives: assert property (@(posedge I_CLK_SYS)
		disable iff (!I_NRST) (I_CE && channel_enable_q[0]) |=> O_PIN_OE[0])
		else $error("enabled pin not driven");
	a_counter_clear: assert property (@(posedge I_CLK_SYS)
		disable iff (!I_NRST)
		(I_CE && wr_cnt[2] && !join_upper_pair) |=> cnt_q[2] == 8'h00)
		else $error("counter write did not clear");
	a_direct_latch: assert property (@(posedge I_CLK_SYS)
		disable iff (!I_NRST)
		(I_CE && wr_per[0] && !channel_enable_q[0] && !join_lower_pair)
		|=> act_q[0].period == $past(I_BUS.wdata))
		else $error("disabled period write not latched");
	a_buffer_hold: assert property (@(posedge I_CLK_SYS)
		disable iff (!I_NRST)
		(I_CE && wr_dty[0] && channel_enable_q[0] && !join_lower_pair
		&& !roll[0] && !center_align_select_q)
		|=> $stable(act_q[0].duty))
		else $error("duty changed without rollover");
	a_gated_tick: assert property (@(posedge I_CLK_SYS)
		disable iff (!I_NRST)
		!en_sync_q[3] && !join_upper_pair |-> !ch_tick[3])
		else $error("clock reached disabled channel");
	a_read_counter: assert property (@(posedge I_CLK_SYS)
		disable iff (!I_NRST)
		(I_CE && I_BUS.rd && I_BUS.addr == ADDR_CNT_BASE)
		|=> O_RDATA == $past(cnt_q[0]))
		else $error("counter read wrong");
	a_joined_pin: assert property (@(posedge I_CLK_SYS)
		disable iff (!I_NRST)
		(I_CE && join_upper_pair && !port_direction_bits_q[3])
		|=> !O_PIN_OE[3])
		else $error("joined low pin still driven");
	c_join: cover property (@(posedge I_CLK_SYS) join_lower_pair && channel_enable_q[0]);
	c_center: cover property (@(posedge I_CLK_SYS) center_align_select_q && down_q[0]);
	c_roll: cover property (@(posedge I_CLK_SYS) roll[2]);

endmodule // pwm4_top
`default_nettype wire

//--- hdl/pwm4_pkg.sv
// shared constants and types of the four-channel waveform generator
package pwm4_pkg;

	// ********************************************
	// register map
	// ********************************************
	localparam logic [7:0] ADDR_CLK_CONCAT = 8'h40;
	localparam logic [7:0] ADDR_SEL_POL    = 8'h41;
	localparam logic [7:0] ADDR_ENABLE     = 8'h42;
	localparam logic [7:0] ADDR_PRESCALE   = 8'h43;
	localparam logic [7:0] ADDR_SCALE0     = 8'h44;
	localparam logic [7:0] ADDR_SCNT0      = 8'h45;
	localparam logic [7:0] ADDR_SCALE1     = 8'h46;
	localparam logic [7:0] ADDR_SCNT1      = 8'h47;
	localparam logic [7:0] ADDR_CNT_BASE   = 8'h48;
	localparam logic [7:0] ADDR_PER_BASE   = 8'h4C;
	localparam logic [7:0] ADDR_DTY_BASE   = 8'h50;
	localparam logic [7:0] ADDR_CONTROL    = 8'h54;
	localparam logic [7:0] ADDR_PORT_DIR   = 8'h58;
	localparam logic [7:0] ADDR_PORT_DATA  = 8'h59;

	// ********************************************
	// field positions and reset values
	// ********************************************
	localparam int JOIN_UPPER_BIT   = 7;
	localparam int JOIN_LOWER_BIT   = 6;
	localparam int CLKA_FIELD_LSB   = 3;
	localparam int CLKB_FIELD_LSB   = 0;
	localparam int SCALED_SEL_LSB   = 4;
	localparam int POLARITY_LSB     = 0;
	localparam int CENTER_ALIGN_BIT = 3;
	localparam logic [7:0] RST_ZERO   = 8'h00;
	localparam logic [7:0] RST_PERIOD = 8'hFF;
	localparam logic [7:0] RST_DUTY   = 8'hFF;
	localparam int NUM_CHAN = 4;

	// ********************************************
	// carriers
	// ********************************************
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_type;

	typedef struct packed {
		logic [7:0] period;
		logic [7:0] duty;
	} per_duty_type;

endpackage : pwm4_pkg

//--- hdl/pwm4_scaler.sv
// prescaled clock A/B plus scaled clock S0/S1 tick generator
`timescale 1ns/1ps
`default_nettype none
module pwm4_scaler
(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	input  wire logic       i_ce,
	// prescale tap and scale value
	input  wire logic       i_run,
	input  wire logic [6:0] i_pre_cnt,
	input  wire logic [6:0] i_pre_prev,
	input  wire logic [2:0] i_div_sel,
	input  wire logic [7:0] i_scale,
	input  wire logic       i_scale_load,
	// ticks
	output logic            o_tick_base,
	output logic            o_tick_scaled,
	output logic [7:0]      o_scnt
);
	import pwm4_pkg::*;

	logic [7:0] scnt_q;
	logic       half_q;
	logic [7:0] tap_full;
	logic [7:0] tap_prev;

	// ********************************************
	// clock A/B: P divided by 2**sel
	// ********************************************
	// a rising edge on bit (sel-1) of the prescaler marks one tick
	assign tap_full = {i_pre_cnt, 1'b1};
	assign tap_prev = {i_pre_prev, 1'b0};
	assign o_tick_base = i_run & ((i_div_sel == 3'd0) ? 1'b1 :
		(tap_full[i_div_sel] & ~tap_prev[i_div_sel]));

	// ********************************************
	// scaled clock: divide by scale+1, then by two
	// ********************************************
	// down counter reloads at zero; 0xFF gives 256 steps
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			scnt_q <= RST_ZERO;
			half_q <= 1'b0;
		end
		else if (i_ce)
		begin
			if (i_scale_load)
				scnt_q <= i_scale;
			else if (o_tick_base)
			begin
				if (scnt_q == 8'h00)
				begin
					scnt_q <= i_scale;
					half_q <= ~half_q;
				end
				else
					scnt_q <= scnt_q - 8'h01;
			end
		end
	end

	assign o_tick_scaled = o_tick_base & (scnt_q == 8'h00) & half_q;
	assign o_scnt        = scnt_q;

endmodule // pwm4_scaler
`default_nettype wire

//--- test/pwm4_tb.sv
// self-checking bench of the four-channel waveform generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pwm4_pkg::*;

	// ****
	// wiring
	// ****
	logic        clk;
	logic        nrst;
	logic        ce;
	bus_req_type bus;
	logic [7:0]  rdata;
	logic [3:0]  pin_out;
	logic [3:0]  pin_oe;
	int          fails;
	int          n_compared;
	int          cycles;

	// pin inputs held at a fixed pattern for the port data read
	pwm4_top u_dut
	(
		.I_CLK_SYS (clk),
		.I_NRST    (nrst),
		.I_CE      (ce),
		.I_BUS     (bus),
		.O_RDATA   (rdata),
		.I_PIN     (4'hA),
		.O_PIN     (pin_out),
		.O_PIN_OE  (pin_oe)
	);

	// 40 MHz clock
	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	// hang guard, far above the longest sequence
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fails++;
			close_out();
		end
	end

	// ****
	// shared tasks
	// ****
	task automatic close_out();
		if (fails == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// strobes last exactly one cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1;
		d = rdata;
	endtask

	task automatic reset_dut();
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
	endtask

	// any window that spans whole periods gives an exact high count
	task automatic measure(input int p, input int n, input int hi_exp);
		int hi;
		hi = 0;
		repeat (n)
		begin
			@(posedge clk);
			#1;
			if (pin_out[p] === 1'b1)
				hi++;
		end
		chk("high cycles", hi[15:0], hi_exp[15:0]);
	endtask

	// one channel alone; counter write restarts it with fresh values
	task automatic wave(input int ch, input logic [7:0] ck, pl, ctl,
		sc, per, dty, input int n, hi_exp);
		reset_dut();
		wr(ADDR_CLK_CONCAT, ck);
		wr(ADDR_SEL_POL, pl);
		wr(ADDR_CONTROL, ctl);
		wr(ADDR_SCALE0, sc);
		wr(ADDR_SCALE1, sc);
		wr(ADDR_PER_BASE + ch[7:0], per);
		wr(ADDR_DTY_BASE + ch[7:0], dty);
		wr(ADDR_ENABLE, 8'h01 << ch);
		wr(ADDR_CNT_BASE + ch[7:0], 8'h00);
		repeat (n) @(posedge clk);
		chk("drive", {15'h0, pin_oe[ch]}, 16'h1);
		measure(ch, n, hi_exp);
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_regs();
		logic [7:0] v;
		reset_dut();
		rd(ADDR_CLK_CONCAT, v); chk("clk reg", v, 8'h00);
		rd(ADDR_SEL_POL, v); chk("sel reg", v, 8'h00);
		rd(ADDR_ENABLE, v); chk("en reg", v, 8'h00);
		rd(ADDR_PER_BASE, v); chk("period", v, RST_PERIOD);
		wr(8'h60, 8'hFF);
		rd(8'h60, v); chk("unmapped", v, 8'h00);
		wr(ADDR_CLK_CONCAT, 8'hA5);
		wr(ADDR_SEL_POL, 8'h5A);
		wr(ADDR_ENABLE, 8'hFF);
		rd(ADDR_CLK_CONCAT, v); chk("clk reg", v, 8'hA5);
		rd(ADDR_SEL_POL, v); chk("sel reg", v, 8'h5A);
		rd(ADDR_ENABLE, v); chk("en reg", v, 8'h0F);
		rd(ADDR_PORT_DATA, v); chk("pins", v[3:0], 4'hA);
	endtask

	// direction bits survive the takeover by an enabled channel
	task automatic t_dir();
		logic [7:0] v;
		reset_dut();
		wr(ADDR_PORT_DIR, 8'h02);
		wr(ADDR_ENABLE, 8'h01);
		repeat (3) @(posedge clk);
		chk("oe on", pin_oe, 4'b0011);
		rd(ADDR_PORT_DIR, v); chk("dir", v, 8'h02);
		wr(ADDR_ENABLE, 8'h00);
		repeat (3) @(posedge clk);
		chk("oe off", pin_oe, 4'b0010);
	endtask

	// prescaler and counter run only while something is enabled
	task automatic t_count();
		logic [7:0] a, b;
		reset_dut();
		rd(ADDR_PRESCALE, a);
		repeat (10) @(posedge clk);
		rd(ADDR_PRESCALE, b); chk("pre idle", b, a);
		wr(ADDR_ENABLE, 8'h01);
		rd(ADDR_CNT_BASE, a);
		repeat (20) @(posedge clk);
		rd(ADDR_CNT_BASE, b); chk("cnt step", b - a, 8'd22);
		// clock enable low for ten edges holds the count
		rd(ADDR_CNT_BASE, a);
		@(posedge clk) ce <= 1'b0;
		repeat (10) @(posedge clk);
		ce <= 1'b1;
		rd(ADDR_CNT_BASE, b); chk("cnt freeze", b - a, 8'd3);
		rd(ADDR_PRESCALE, a);
		rd(ADDR_PRESCALE, b);
		chk("pre run", {1'b0, b[6:0] - a[6:0]}, 8'd2);
		wr(ADDR_CNT_BASE, 8'h55);
		rd(ADDR_CNT_BASE, a); chk("cnt clr", a < 8'd4, 1'b1);
		wr(ADDR_ENABLE, 8'h00);
		rd(ADDR_CNT_BASE, a);
		repeat (10) @(posedge clk);
		rd(ADDR_CNT_BASE, b); chk("cnt gate", b, a);
	endtask

	// duty written mid-period waits for rollover
	task automatic t_buffer();
		logic [7:0] v;
		reset_dut();
		wr(ADDR_PER_BASE, 8'd99);
		wr(ADDR_DTY_BASE, 8'd98);
		wr(ADDR_ENABLE, 8'h01);
		wr(ADDR_CNT_BASE, 8'h00);
		repeat (30) @(posedge clk);
		wr(ADDR_DTY_BASE, 8'd10);
		rd(ADDR_DTY_BASE, v); chk("duty rd", v, 8'd10);
		repeat (20) @(posedge clk);
		chk("old duty", pin_out[0], 1'b0);
		repeat (150) @(posedge clk);
		measure(0, 100, 90);
	endtask

	// joined pair: 16-bit period 0x0013, duty 0x0009
	task automatic t_join(input int hi);
		reset_dut();
		wr(ADDR_CLK_CONCAT, (hi == 0) ? 8'h40 : 8'h80);
		wr(ADDR_PER_BASE + hi[7:0], 8'h00);
		wr(ADDR_PER_BASE + hi[7:0] + 8'h01, 8'h13);
		wr(ADDR_DTY_BASE + hi[7:0], 8'h00);
		wr(ADDR_DTY_BASE + hi[7:0] + 8'h01, 8'h09);
		wr(ADDR_ENABLE, 8'h03 << hi);
		wr(ADDR_CNT_BASE + hi[7:0], 8'h00);
		repeat (40) @(posedge clk);
		measure(hi, 100, 55);
		chk("low pin oe", pin_oe[hi + 1], 1'b0);
		wr(ADDR_PORT_DIR, 8'h02 << hi);
		wr(ADDR_PORT_DATA, 8'hFF);
		repeat (3) @(posedge clk);
		chk("gpio oe", pin_oe[hi + 1], 1'b1);
		chk("gpio out", pin_out[hi + 1], 1'b1);
	endtask

	// main sequence
	initial
	begin
		nrst = 1'b0;
		ce = 1'b1;
		bus = '0;
		fails = 0;
		n_compared = 0;
		cycles = 0;
		t_regs();
		t_dir();
		t_count();
		t_buffer();
		t_join(0);
		t_join(2);
		wave(0, 8'h00, 8'h00, 8'h00, 8'h00, 8'd9, 8'd3, 100, 70);
		wave(1, 8'h00, 8'h02, 8'h00, 8'h00, 8'd9, 8'd3, 100, 30);
		wave(0, 8'h00, 8'h00, 8'h00, 8'h00, 8'd9, 8'hFF, 50, 50);
		wave(3, 8'h00, 8'h08, 8'h00, 8'h00, 8'd9, 8'hFF, 50, 0);
		wave(1, 8'h18, 8'h00, 8'h00, 8'h00, 8'd9, 8'd3, 160, 112);
		wave(0, 8'h38, 8'h00, 8'h00, 8'h00, 8'd3, 8'd1, 512, 384);
		wave(2, 8'h01, 8'h00, 8'h00, 8'h00, 8'd9, 8'd3, 40, 28);
		wave(0, 8'h00, 8'h10, 8'h00, 8'h01, 8'd9, 8'd3, 80, 56);
		wave(3, 8'h01, 8'h80, 8'h00, 8'h02, 8'd4, 8'd1, 120, 96);
		wave(2, 8'h00, 8'h00, 8'h08, 8'h00, 8'd10, 8'd4, 100, 55);
		close_out();
	end

endmodule // testbench
`default_nettype wire
